// ### pwm_consts.svh
// pwm_consts.svh: register indices, field positions, reset values
// assumes an apb slave where byte address = 4 * register index
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH
`define IDX_GLOBAL 10'h00B
`define IDX_FLAGS1 10'h00C
`define IDX_FLAGS2 10'h00D
`define IDX_TBCNT 10'h011
`define IDX_TBCTL 10'h012
`define IDX_CH1_DUTY 10'h015
`define IDX_CH1_SHD 10'h016
`define IDX_CH1_CTL 10'h017
`define IDX_CH2_DUTY 10'h01B
`define IDX_CH2_SHD 10'h01C
`define IDX_CH2_CTL 10'h01D
`define IDX_PORTC_DIR 10'h087
`define IDX_ENABLES1 10'h08C
`define IDX_ENABLES2 10'h08D
`define IDX_PERIOD 10'h092
`define FLD_RUN 2
`define FLD_PRE 1:0
`define FLD_POST 6:3
`define FLD_FRAC 5:4
`define FLD_MODE 3:2
`define MODE_PWM 2'b11
`define FLD_TB_FLAG 1
`define CH1_DIR_BIT 2
`define RST_ZERO 8'h00
`define RST_FF 8'hFF
`define MASK_TBCTL 8'h7F
`define MASK_CHCTL 8'h3F
`define MASK_BIT0 8'h01
`define TICK_MASK_1 6'h03
`define TICK_MASK_4 6'h0F
`define TICK_MASK_16 6'h3F
`endif

// ### pwm_pkg.sv
// pwm_pkg: types shared by the pwm unit and its channels
// assumes pwm_consts.svh supplies all numbers
package pwm_pkg;
  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV4 = 2'b01,
    PRE_DIV16 = 2'b10,
    PRE_DIV16B = 2'b11
  } prescale_e;

  typedef struct packed {
    logic [7:0] shadow;
    logic [1:0] frac;
    logic wave;
  } chan_s;

  typedef struct packed {
    logic [7:0] global_ctrl;
    logic [7:0] flags_one;
    logic [7:0] flags_two;
    logic [7:0] enables_one;
    logic [7:0] enables_two;
    logic [7:0] tb_count;
    logic [7:0] tb_ctrl;
    logic [7:0] period;
    logic [7:0] portc_dir;
    logic [7:0] ch1_duty;
    logic [7:0] ch1_ctrl;
    logic [7:0] ch2_duty;
    logic [7:0] ch2_ctrl;
    logic [5:0] div;
    logic [3:0] post;
    logic ch1_oe;
    logic ch2_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } unit_s;
endpackage : pwm_pkg

// ### pwm_channel.sv
// pwm_channel: double-buffered duty latch and output waveform of one channel
// assumes boundary and ext_count come from the shared timebase, same clock
`timescale 1ns/10ps
`include "pwm_consts.svh"
module pwm_channel (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timebase
  input wire logic boundary,
  input wire logic [9:0] ext_count,
  // configuration
  input wire logic pwm_mode,
  input wire logic [7:0] duty_low,
  input wire logic [1:0] duty_frac,
  input wire logic shadow_wr,
  input wire logic [7:0] shadow_wdata,
  // results
  output logic [7:0] shadow,
  output logic wave
);
  import pwm_pkg::*;

  chan_s s;
  chan_s n;
  logic [9:0] duty_in;
  logic [9:0] duty_buf;

  assign duty_in = {duty_low, duty_frac};
  assign duty_buf = {s.shadow, s.frac};
  assign shadow = s.shadow;
  assign wave = s.wave;

  always_comb begin
    n = s;
    if (!pwm_mode) begin
      // outside pwm the latch is plain storage and the pin rests low
      n.wave = 1'b0;
      if (shadow_wr) begin
        n.shadow = shadow_wdata;
      end
    end else if (boundary) begin
      n.shadow = duty_low;
      n.frac = duty_frac;
      n.wave = (duty_in != 10'h000);
    end else if (ext_count == duty_buf) begin
      // a duty beyond the period never matches, so the pin stays high
      n.wave = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pin_set_a: assert property (boundary && pwm_mode && duty_in != 10'h000 |=> wave)
    else $error("pin not set at period start");
  zero_duty_a: assert property (boundary && pwm_mode && duty_in == 10'h000 |=> !wave)
    else $error("pin set with zero duty");
  shadow_load_a: assert property (boundary && pwm_mode |=> duty_buf == $past(duty_in))
    else $error("duty not latched at boundary");
  shadow_hold_a: assert property (pwm_mode && !boundary |=> $stable(duty_buf))
    else $error("shadow changed mid period");
  clear_match_a: assert property (pwm_mode && !boundary && ext_count == duty_buf |=> !wave)
    else $error("pin not cleared on match");
  hold_high_a: assert property (pwm_mode && wave && !boundary && ext_count != duty_buf
                                |=> wave)
    else $error("pin fell without match");
endmodule : pwm_channel

// ### double_buffered_pwm_unit.sv
// double_buffered_pwm_unit: shared 8-bit timebase, two pwm channels, apb registers
// assumes an apb3 master on pclk; pins leave through output and enable pairs
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`include "pwm_consts.svh"
module double_buffered_pwm_unit #(
  parameter int ADDR_W = 12,
  parameter int CH2_DIR_BIT = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel one pin
  output logic channel_one_output_pin,
  output logic channel_one_output_enable,
  // channel two pin
  output logic channel_two_output_pin,
  output logic channel_two_output_enable
);
  import pwm_pkg::*;

  localparam unit_s UNIT_RST = '{
    period: `RST_FF,
    portc_dir: `RST_FF,
    default: '0
  };

  unit_s s;
  unit_s n;

  logic [9:0] idx;
  logic setup;
  logic wr;
  logic run;
  prescale_e pre;
  prescale_e pre_nxt;
  logic tick;
  logic at_limit;
  logic match;
  logic [9:0] ext_count;
  logic ch1_pwm;
  logic ch2_pwm;
  logic [7:0] ch1_shadow;
  logic [7:0] ch2_shadow;
  logic tb_wr;

  // mask of divider bits that must all be ones for the count to step
  function automatic logic [5:0] tick_mask(input prescale_e p);
    logic [5:0] m;
    m = `TICK_MASK_16;
    if (p == PRE_DIV1) begin
      m = `TICK_MASK_1;
    end else if (p == PRE_DIV4) begin
      m = `TICK_MASK_4;
    end
    return m;
  endfunction : tick_mask

  // two bits below the count: quarter phase at 1:1, prescaler bits otherwise
  function automatic logic [1:0] ext_low(input logic [5:0] d, input prescale_e p);
    logic [1:0] b;
    b = d[5:4];
    if (p == PRE_DIV1) begin
      b = d[1:0];
    end else if (p == PRE_DIV4) begin
      b = d[3:2];
    end
    return b;
  endfunction : ext_low

  function automatic logic is_mapped(input logic [9:0] i);
    logic ok;
    ok = 1'b0;
    if (i == `IDX_GLOBAL || i == `IDX_FLAGS1 || i == `IDX_FLAGS2) begin
      ok = 1'b1;
    end else if (i == `IDX_TBCNT || i == `IDX_TBCTL || i == `IDX_PERIOD) begin
      ok = 1'b1;
    end else if (i == `IDX_CH1_DUTY || i == `IDX_CH1_SHD || i == `IDX_CH1_CTL) begin
      ok = 1'b1;
    end else if (i == `IDX_CH2_DUTY || i == `IDX_CH2_SHD || i == `IDX_CH2_CTL) begin
      ok = 1'b1;
    end else if (i == `IDX_PORTC_DIR || i == `IDX_ENABLES1 || i == `IDX_ENABLES2) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : is_mapped

  function automatic logic [7:0] rd_byte(input logic [9:0] i, input unit_s u,
                                         input logic [7:0] sh1, input logic [7:0] sh2);
    logic [7:0] v;
    v = 8'h00;
    if (i == `IDX_GLOBAL) begin
      v = u.global_ctrl;
    end else if (i == `IDX_FLAGS1) begin
      v = u.flags_one;
    end else if (i == `IDX_FLAGS2) begin
      v = u.flags_two;
    end else if (i == `IDX_TBCNT) begin
      v = u.tb_count;
    end else if (i == `IDX_TBCTL) begin
      v = u.tb_ctrl;
    end else if (i == `IDX_PERIOD) begin
      v = u.period;
    end else if (i == `IDX_CH1_DUTY) begin
      v = u.ch1_duty;
    end else if (i == `IDX_CH1_SHD) begin
      v = sh1;
    end else if (i == `IDX_CH1_CTL) begin
      v = u.ch1_ctrl;
    end else if (i == `IDX_CH2_DUTY) begin
      v = u.ch2_duty;
    end else if (i == `IDX_CH2_SHD) begin
      v = sh2;
    end else if (i == `IDX_CH2_CTL) begin
      v = u.ch2_ctrl;
    end else if (i == `IDX_PORTC_DIR) begin
      v = u.portc_dir;
    end else if (i == `IDX_ENABLES1) begin
      v = u.enables_one;
    end else if (i == `IDX_ENABLES2) begin
      v = u.enables_two;
    end
    return v;
  endfunction : rd_byte

  assign idx = paddr[11:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && s.pready && pwrite;
  assign tb_wr = wr && (idx == `IDX_TBCNT || idx == `IDX_TBCTL);
  assign run = s.tb_ctrl[`FLD_RUN];
  assign pre = prescale_e'(s.tb_ctrl[`FLD_PRE]);
  // the count steps once per four clocks times the prescale factor
  assign tick = run && ((s.div & tick_mask(pre)) == tick_mask(pre));
  assign at_limit = (s.tb_count == s.period);
  assign match = tick && at_limit;
  // ten-bit compare base; resolution is bounded by clock over pwm rate
  // the channels compare against the value the extended count takes next, so the
  // registered pin falls in the first cycle at which count and duty agree and the
  // high time is exactly duty times the prescale factor clocks instead of one clock longer
  assign pre_nxt = prescale_e'(n.tb_ctrl[`FLD_PRE]);
  assign ext_count = {n.tb_count, ext_low(n.div, pre_nxt)};
  assign ch1_pwm = (s.ch1_ctrl[`FLD_MODE] == `MODE_PWM);
  assign ch2_pwm = (s.ch2_ctrl[`FLD_MODE] == `MODE_PWM);

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign channel_one_output_enable = s.ch1_oe;
  assign channel_two_output_enable = s.ch2_oe;

  always_comb begin
    n = s;
    // timebase
    if (run) begin
      n.div = s.div + 6'h01;
    end
    if (tick) begin
      if (at_limit) begin
        n.tb_count = 8'h00;
      end else begin
        n.tb_count = s.tb_count + 8'h01;
      end
    end
    // postscaler counts period matches only; the period itself ignores it
    if (match) begin
      if (s.post == s.tb_ctrl[`FLD_POST]) begin
        n.post = 4'h0;
      end else begin
        n.post = s.post + 4'h1;
      end
    end
    // apb: answer one cycle after setup, zero wait states
    n.pready = setup;
    if (setup) begin
      n.prdata = {24'h000000, rd_byte(idx, s, ch1_shadow, ch2_shadow)};
      n.pslverr = !is_mapped(idx);
    end
    if (wr) begin
      if (idx == `IDX_GLOBAL) begin
        n.global_ctrl = pwdata[7:0];
      end else if (idx == `IDX_FLAGS1) begin
        n.flags_one = pwdata[7:0];
      end else if (idx == `IDX_FLAGS2) begin
        n.flags_two = pwdata[7:0] & `MASK_BIT0;
      end else if (idx == `IDX_TBCNT) begin
        // writing the count also restarts prescaler and postscaler
        n.tb_count = pwdata[7:0];
        n.div = 6'h00;
        n.post = 4'h0;
      end else if (idx == `IDX_TBCTL) begin
        n.tb_ctrl = pwdata[7:0] & `MASK_TBCTL;
        n.post = 4'h0;
      end else if (idx == `IDX_PERIOD) begin
        n.period = pwdata[7:0];
      end else if (idx == `IDX_CH1_DUTY) begin
        n.ch1_duty = pwdata[7:0];
      end else if (idx == `IDX_CH1_CTL) begin
        n.ch1_ctrl = pwdata[7:0] & `MASK_CHCTL;
      end else if (idx == `IDX_CH2_DUTY) begin
        n.ch2_duty = pwdata[7:0];
      end else if (idx == `IDX_CH2_CTL) begin
        n.ch2_ctrl = pwdata[7:0] & `MASK_CHCTL;
      end else if (idx == `IDX_PORTC_DIR) begin
        n.portc_dir = pwdata[7:0];
      end else if (idx == `IDX_ENABLES1) begin
        n.enables_one = pwdata[7:0];
      end else if (idx == `IDX_ENABLES2) begin
        n.enables_two = pwdata[7:0] & `MASK_BIT0;
      end
    end
    // hardware set beats a software clear in the same cycle
    if (match && s.post == s.tb_ctrl[`FLD_POST]) begin
      n.flags_one[`FLD_TB_FLAG] = 1'b1;
    end
    // pin is driven only in pwm mode with its direction bit cleared
    n.ch1_oe = ch1_pwm && !n.portc_dir[`CH1_DIR_BIT];
    n.ch2_oe = ch2_pwm && !n.portc_dir[CH2_DIR_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= UNIT_RST;
    end else begin
      s <= n;
    end
  end

  // both channels hang on the same timebase and boundary
  pwm_channel u_ch1 (
    .pclk(pclk),
    .presetn(presetn),
    .boundary(match),
    .ext_count(ext_count),
    .pwm_mode(ch1_pwm),
    .duty_low(s.ch1_duty),
    .duty_frac(s.ch1_ctrl[`FLD_FRAC]),
    .shadow_wr(wr && idx == `IDX_CH1_SHD),
    .shadow_wdata(pwdata[7:0]),
    .shadow(ch1_shadow),
    .wave(channel_one_output_pin)
  );

  pwm_channel u_ch2 (
    .pclk(pclk),
    .presetn(presetn),
    .boundary(match),
    .ext_count(ext_count),
    .pwm_mode(ch2_pwm),
    .duty_low(s.ch2_duty),
    .duty_frac(s.ch2_ctrl[`FLD_FRAC]),
    .shadow_wr(wr && idx == `IDX_CH2_SHD),
    .shadow_wdata(pwdata[7:0]),
    .shadow(ch2_shadow),
    .wave(channel_two_output_pin)
  );

  // helper: clocks since the previous count step, for the prescale check
  logic [6:0] gap_r;
  logic gap_ok_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 7'h00;
      gap_ok_r <= 1'b0;
    end else if (tick) begin
      gap_r <= 7'h00;
      gap_ok_r <= !tb_wr;
    end else if (tb_wr || !run) begin
      gap_r <= 7'h00;
      gap_ok_r <= 1'b0;
    end else begin
      gap_r <= gap_r + 7'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence shd_wr_s;
    wr && idx == `IDX_CH1_SHD && ch1_pwm;
  endsequence

  apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  period_wrap_a: assert property (match && !tb_wr |=> s.tb_count == 8'h00)
    else $error("count did not wrap at limit");
  count_step_a: assert property (tick && !at_limit && !tb_wr
                                 |=> s.tb_count == $past(s.tb_count) + 8'h01)
    else $error("count did not step");
  run_stop_a: assert property (!run && !tb_wr |=> $stable(s.tb_count))
    else $error("count moved while stopped");
  prescale_gap_a: assert property (tick && gap_ok_r |-> gap_r == {1'b0, tick_mask(pre)})
    else $error("wrong prescale spacing");
  postscale_a: assert property (match && s.post == s.tb_ctrl[`FLD_POST]
                                |=> s.flags_one[`FLD_TB_FLAG])
    else $error("match flag not set");
  readonly_a: assert property ((shd_wr_s and !match) |=> $stable(ch1_shadow))
    else $error("shadow written in pwm mode");
  oe_mode_a: assert property (!ch1_pwm
                              |=> !channel_one_output_enable ##0 !channel_one_output_pin)
    else $error("pin driven outside pwm");
  dir_gate_a: assert property (s.portc_dir[`CH1_DIR_BIT] && !wr
                               |=> !channel_one_output_enable)
    else $error("pin enabled while input");
  dir_gate_two_a: assert property (s.portc_dir[CH2_DIR_BIT] && !wr
                                   |=> !channel_two_output_enable)
    else $error("second pin enabled while input");
  slave_err_a: assert property ((setup_s and !is_mapped(idx)) |=> pslverr)
    else $error("no error for unmapped register");
  idle_ready_a: assert property (!psel |=> !pready)
    else $error("ready without a transfer");
  count_load_a: assert property (wr && idx == `IDX_TBCNT |=> s.tb_count == $past(pwdata[7:0]))
    else $error("count write not taken");
endmodule : double_buffered_pwm_unit

// ### pin_monitor.sv
// pin_monitor: external load on one pwm pin, timing high time and period
// assumes pin and enable come from flops on pclk; an undriven pin reads as low
`timescale 1ns/10ps
module pin_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin
  input wire logic pin,
  input wire logic oe,
  // measurements
  output int high_len,
  output int period_len
);
  logic last;
  int hcnt;
  int pcnt;
  // no pull on the line, so a released pin is taken as low, never as the last value
  wire logic lvl = pin & oe;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
      hcnt <= 0;
      pcnt <= 0;
      high_len <= 0;
      period_len <= 0;
    end else begin
      last <= lvl;
      pcnt <= (lvl && !last) ? 1 : pcnt + 1;
      if (lvl && !last) begin
        period_len <= pcnt;
        hcnt <= 1;
      end else if (lvl) begin
        hcnt <= hcnt + 1;
      end else if (last) begin
        high_len <= hcnt;
      end
    end
  end
endmodule : pin_monitor

// ### double_buffered_pwm_unit_tb.sv
// double_buffered_pwm_unit_tb: registers over apb, waveform timing, shared timebase
// assumes pin_monitor beside it and pwm_consts.svh on the include path
`timescale 1ns/10ps
`include "pwm_consts.svh"
module double_buffered_pwm_unit_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin1;
  logic oe1;
  logic pin2;
  logic oe2;
  int high1, per1, high2, per2;
  int fail_count = 0;
  int checks_done = 0;
  int mdl [int];
  int rw [$] = '{`IDX_GLOBAL, `IDX_FLAGS2, `IDX_ENABLES1, `IDX_ENABLES2, `IDX_PERIOD,
    `IDX_CH1_DUTY, `IDX_CH2_DUTY, `IDX_CH1_CTL, `IDX_CH2_CTL, `IDX_TBCTL, `IDX_PORTC_DIR};
  logic [31:0] rd;
  logic err;
  int pr, duty, pre, n, len;

  always #50 pclk = ~pclk;

  double_buffered_pwm_unit #(.ADDR_W(12), .CH2_DIR_BIT(1)) double_buffered_pwm_unit_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_one_output_pin(pin1), .channel_one_output_enable(oe1),
    .channel_two_output_pin(pin2), .channel_two_output_enable(oe2));
  pin_monitor mon1 (.pclk(pclk), .presetn(presetn), .pin(pin1), .oe(oe1),
    .high_len(high1), .period_len(per1));
  pin_monitor mon2 (.pclk(pclk), .presetn(presetn), .pin(pin2), .oe(oe2),
    .high_len(high2), .period_len(per2));

  function automatic int mask_of(input int idx);
    case (idx)
      `IDX_TBCTL: return 'h7F;
      `IDX_CH1_CTL, `IDX_CH2_CTL: return 'h3F;
      `IDX_FLAGS2, `IDX_ENABLES2: return 'h01;
      default: return 'hFF;
    endcase
  endfunction : mask_of

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w == 50) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
    mdl[idx] = v & mask_of(idx);
  endtask : wr

  task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, rd, exp);
    check("slave error", err, 1'b0);
  endtask : rdc

  task automatic wait_rise();
    logic p;
    int k;
    p = pin1;
    for (k = 0; k < 5000; k++) begin
      @(posedge pclk);
      if (pin1 === 1'b1 && p !== 1'b1) break;
      p = pin1;
    end
    if (k == 5000) fail_count++;
  endtask : wait_rise

  task automatic count_level(input int cycles, input logic lvl, output int cnt);
    cnt = 0;
    repeat (cycles) begin
      @(posedge pclk);
      if (pin1 === lvl) cnt++;
    end
  endtask : count_level

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // roughly four times the longest run the random periods can give
  initial begin
    #4000000;
    fail_count++;
    wrap_up();
  end

  initial begin
    n = $urandom(32'h807F);
    foreach (rw[i]) mdl[rw[i]] = 0;
    mdl[`IDX_FLAGS1] = 0;
    mdl[`IDX_TBCNT] = 0;
    mdl[`IDX_CH1_SHD] = 0;
    mdl[`IDX_CH2_SHD] = 0;
    mdl[`IDX_PERIOD] = 'hFF;
    mdl[`IDX_PORTC_DIR] = 'hFF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (mdl[i]) rdc("reset value", 10'(i), mdl[i]);
    foreach (rw[i]) begin
      wr(10'(rw[i]), 8'($urandom));
      rdc("readback", 10'(rw[i]), mdl[rw[i]]);
    end
    wr(`IDX_TBCTL, 8'h00);
    wr(`IDX_CH1_CTL, 8'h00);
    wr(`IDX_CH2_CTL, 8'h00);
    wr(`IDX_CH1_SHD, 8'hA5);
    rdc("shadow outside pwm", `IDX_CH1_SHD, 8'hA5);
    apb(1'b0, 10'h001, 8'h00);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test registers done");
    // duty kept below the period so the full resolution is usable
    pr = 2 + $urandom % 6;
    wr(`IDX_PERIOD, 8'(pr));
    // a count left above the new limit would have to run round through 255 first
    wr(`IDX_TBCNT, 8'h00);
    wr(`IDX_CH2_DUTY, 8'h01);
    wr(`IDX_CH2_CTL, 8'h0C);
    for (int c = 0; c < 4; c++) begin
      pre = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      len = (pr + 1) * 4 * pre;
      duty = 1 + $urandom % ((pr + 1) * 4 - 1);
      wr(`IDX_CH1_DUTY, 8'(duty >> 2));
      wr(`IDX_PORTC_DIR, 8'hF9);
      wr(`IDX_TBCTL, 8'(($urandom % 16) * 8 + 4 + c));
      wr(`IDX_CH1_CTL, 8'((duty % 4) * 16 + 12));
      repeat (4 * len) @(posedge pclk);
      check("period", per1, len);
      check("high time", high1, duty * pre);
      check("shared period", per2, len);
      check("second high time", high2, 4 * pre);
      check("pin enable", oe1, 1'b1);
    end
    $display("test waveform done");
    wait_rise();
    rdc("shadow loaded", `IDX_CH1_SHD, duty >> 2);
    // new duty stays below the period so the pin still falls and is measured
    n = 1 + $urandom % pr;
    wr(`IDX_CH1_DUTY, 8'(n));
    wr(`IDX_CH1_SHD, 8'h5A);
    rdc("shadow held", `IDX_CH1_SHD, duty >> 2);
    wait_rise();
    rdc("shadow new", `IDX_CH1_SHD, n);
    repeat (2 * len) @(posedge pclk);
    check("buffered high time", high1, (n * 4 + duty % 4) * 16);
    $display("test buffering done");
    wr(`IDX_CH1_DUTY, 8'h00);
    wr(`IDX_CH1_CTL, 8'h0C);
    repeat (len) @(posedge pclk);
    count_level(len, 1'b1, n);
    check("zero duty high cycles", n, 0);
    wr(`IDX_CH1_DUTY, 8'hFF);
    wr(`IDX_CH1_CTL, 8'h3C);
    repeat (len) @(posedge pclk);
    count_level(len, 1'b0, n);
    check("long duty low cycles", n, 0);
    $display("test duty limits done");
    wr(`IDX_CH1_CTL, 8'h00);
    wr(`IDX_PORTC_DIR, 8'hFF);
    count_level(20, 1'b1, n);
    check("idle mode high cycles", n, 0);
    check("idle mode enable", oe1, 1'b0);
    check("input pin enable", oe2, 1'b0);
    $display("test pin control done");
    len = (pr + 1) * 4;
    wr(`IDX_TBCTL, 8'h04);
    wr(`IDX_FLAGS1, 8'h00);
    repeat (2 * len) @(posedge pclk);
    rdc("flag each match", `IDX_FLAGS1, 8'h02);
    wr(`IDX_TBCTL, 8'h1C);
    wr(`IDX_FLAGS1, 8'h00);
    repeat (2 * len) @(posedge pclk);
    rdc("flag before fourth match", `IDX_FLAGS1, 8'h00);
    repeat (4 * len) @(posedge pclk);
    rdc("flag after fourth match", `IDX_FLAGS1, 8'h02);
    wr(`IDX_TBCTL, 8'h00);
    wr(`IDX_TBCNT, 8'h01);
    repeat (100) @(posedge pclk);
    rdc("stopped count", `IDX_TBCNT, 8'h01);
    $display("test timebase done");
    wrap_up();
  end
endmodule : double_buffered_pwm_unit_tb
